// *** rtl/acpl_ctrl.sv ***
// Control-pin logic of an eight-channel simultaneous-sampling converter, with an AXI4-Lite register port.
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module acpl_ctrl
	import acpl_pkg::*;
#(
	parameter int CHANNELS = ACPL_CHANNELS,
	parameter int CODE_W = ACPL_CODE_W
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Control pins from the host
	input wire logic power_down_n,
	input wire logic input_span_select,
	input wire logic interface_select,
	input wire logic sample_start_group_a,
	input wire logic sample_start_group_b,
	input wire logic reset_pin,
	input wire logic chip_select_n,
	input wire logic read_strobe_sclk,
	// Shared pin: mode select input, or data bit 15 in parallel word mode
	input wire logic byte_mode_select_in,
	// Converter core
	output logic [2:0] adc_channel,
	input wire logic [CODE_W-1:0] adc_code,
	// Readout pins
	output logic busy,
	output logic [ACPL_BUS_W-1:0] data_bus_out,
	output logic data_bus_oe_n,
	output logic serial_out_a,
	output logic serial_out_b,
	output logic serial_oe_n,
	output logic first_data,
	output logic first_data_oe_n,
	// Power state
	output logic power_standby,
	output logic power_shutdown
);
	// ********************************
	// Pin synchronisation
	// ********************************
	logic [ACPL_SYNC_W-1:0] pins_raw;
	logic [ACPL_SYNC_W-1:0] pins_now;
	logic [ACPL_SYNC_W-1:0] pins_prev;

	assign pins_raw = {byte_mode_select_in, read_strobe_sclk, chip_select_n, reset_pin, sample_start_group_b,
		sample_start_group_a, interface_select, input_span_select, power_down_n};

	acpl_sync #(.WIDTH(ACPL_SYNC_W)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in(pins_raw),
		.level_out(pins_now),
		.level_prev(pins_prev)
	);

	logic pd_n, span, rst_pin, cs_n, dual;
	logic rise_a, rise_b, cs_fall, cs_rise, dual_fall, dual_rise;
	acpl_mode_t mode;

	assign pd_n = pins_now[0];
	assign span = pins_now[1];
	assign rst_pin = pins_now[5];
	assign cs_n = pins_now[6];
	assign dual = pins_now[7];
	assign rise_a = pins_now[3] & ~pins_prev[3];
	assign rise_b = pins_now[4] & ~pins_prev[4];
	assign cs_fall = ~cs_n & pins_prev[6];
	assign cs_rise = cs_n & ~pins_prev[6];
	assign dual_fall = ~dual & pins_prev[7];
	assign dual_rise = dual & ~pins_prev[7];

	always_comb begin
		if (!pins_now[2]) begin
			mode = ACPL_MODE_PAR_WORD;
		end else if (pins_now[8]) begin
			mode = ACPL_MODE_PAR_BYTE;
		end else begin
			mode = ACPL_MODE_SERIAL;
		end
	end

	// ********************************
	// Power-down
	// ********************************
	// A low level is obeyed whenever it is seen; the host owns the recovery wait after release.
	assign power_standby = ~pd_n & ~span;
	assign power_shutdown = ~pd_n & span;

	logic hold_logic;
	assign hold_logic = rst_pin | ~pd_n;

	// ********************************
	// Registers
	// ********************************
	logic start_en_ff;
	logic [7:0] conv_len_ff;
	logic [2:0] res_sel_ff;
	logic [CODE_W-1:0] result_ff [CHANNELS];
	logic valid_ff;

	// ********************************
	// Conversion
	// ********************************
	acpl_cv_t cv_ff;
	logic hold_a_ff, hold_b_ff;
	logic [2:0] cv_ch_ff;
	logic [7:0] cv_cnt_ff;
	logic start_ok;

	// Edges during reset, power-down or an active conversion are dropped.
	assign start_ok = start_en_ff & ~hold_logic & (cv_ff != ACPL_CV_RUN);
	assign busy = (cv_ff == ACPL_CV_RUN);
	assign adc_channel = cv_ch_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn || hold_logic) begin
			cv_ff <= ACPL_CV_IDLE;
			hold_a_ff <= 1'b0;
			hold_b_ff <= 1'b0;
			cv_ch_ff <= 3'h0;
			cv_cnt_ff <= 8'h00;
		end else begin
			unique case (cv_ff)
				ACPL_CV_IDLE, ACPL_CV_HOLD: begin
					// Both groups must be held before the converter runs all channels.
					if ((hold_a_ff | (start_ok & rise_a)) && (hold_b_ff | (start_ok & rise_b))) begin
						cv_ff <= ACPL_CV_RUN;
						hold_a_ff <= 1'b0;
						hold_b_ff <= 1'b0;
						cv_ch_ff <= 3'h0;
						cv_cnt_ff <= 8'h00;
					end else if (start_ok && (rise_a || rise_b)) begin
						cv_ff <= ACPL_CV_HOLD;
						hold_a_ff <= hold_a_ff | rise_a;
						hold_b_ff <= hold_b_ff | rise_b;
					end
				end
				ACPL_CV_RUN: begin
					if (cv_cnt_ff >= conv_len_ff - 8'h01) begin
						cv_cnt_ff <= 8'h00;
						if (cv_ch_ff == 3'(CHANNELS - 1)) begin
							cv_ff <= ACPL_CV_IDLE;
						end else begin
							cv_ch_ff <= cv_ch_ff + 3'h1;
						end
					end else begin
						cv_cnt_ff <= cv_cnt_ff + 8'h01;
					end
				end
			endcase
		end
	end

	logic latch_now;
	assign latch_now = busy & (cv_cnt_ff >= conv_len_ff - 8'h01);

	always_ff @(posedge aclk) begin
		if (!aresetn || rst_pin) begin
			for (int i = 0; i < CHANNELS; i++) begin
				result_ff[i] <= '0;
			end
		end else if (latch_now) begin
			result_ff[cv_ch_ff] <= adc_code;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || hold_logic) begin
			valid_ff <= 1'b0;
		end else if (cv_ff == ACPL_CV_RUN && cv_ff != ACPL_CV_IDLE && latch_now && cv_ch_ff == 3'(CHANNELS - 1)) begin
			valid_ff <= 1'b1;
		end else if (cv_ff != ACPL_CV_RUN && start_ok && (rise_a || rise_b)) begin
			valid_ff <= 1'b0;
		end
	end

	// ********************************
	// Readout
	// ********************************
	// Readout never looks at the start pins, so data can be read at any start level.
	logic rd_started_ff;
	logic [3:0] rd_idx_ff;
	logic [3:0] sh_bit_ff;
	logic [1:0] sh_ch_ff;
	logic [ACPL_BUS_W-1:0] bus_ff;
	logic ser_a_ff, ser_b_ff, first_ff;
	logic [CODE_W-1:0] word_now;

	assign word_now = result_ff[mode == ACPL_MODE_PAR_BYTE ? rd_idx_ff[3:1] : rd_idx_ff[2:0]];

	always_ff @(posedge aclk) begin
		if (!aresetn || rst_pin || cs_fall) begin
			rd_started_ff <= 1'b0;
			rd_idx_ff <= 4'h0;
			sh_bit_ff <= 4'h0;
			sh_ch_ff <= 2'h0;
		end else if (!cs_n) begin
			if (mode != ACPL_MODE_SERIAL && dual_fall) begin
				rd_started_ff <= 1'b1;
				rd_idx_ff <= rd_started_ff ? rd_idx_ff + 4'h1 : 4'h0;
			end else if (mode == ACPL_MODE_SERIAL && dual_rise) begin
				if (sh_bit_ff == 4'(CODE_W - 1)) begin
					sh_bit_ff <= 4'h0;
					sh_ch_ff <= sh_ch_ff + 2'h1;
				end else begin
					sh_bit_ff <= sh_bit_ff + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || rst_pin) begin
			bus_ff <= '0;
			ser_a_ff <= 1'b0;
			ser_b_ff <= 1'b0;
			first_ff <= 1'b0;
		end else begin
			if (mode == ACPL_MODE_PAR_BYTE) begin
				bus_ff <= rd_idx_ff[0] ? {8'h00, word_now[7:0]}
					: {8'h00, {2{word_now[CODE_W-1]}}, word_now[CODE_W-1:8]};
			end else begin
				bus_ff <= {{(ACPL_BUS_W - CODE_W){word_now[CODE_W-1]}}, word_now};
			end
			ser_a_ff <= result_ff[{1'b0, sh_ch_ff}][4'(CODE_W - 1) - sh_bit_ff];
			ser_b_ff <= result_ff[{1'b1, sh_ch_ff}][4'(CODE_W - 1) - sh_bit_ff];
			if (mode == ACPL_MODE_SERIAL) begin
				first_ff <= (sh_ch_ff == 2'h0);
			end else if (mode == ACPL_MODE_PAR_BYTE) begin
				first_ff <= rd_started_ff & (rd_idx_ff[3:1] == 3'h0);
			end else begin
				first_ff <= rd_started_ff & (rd_idx_ff == 4'h0);
			end
		end
	end

	assign data_bus_out = bus_ff;
	assign serial_out_a = ser_a_ff;
	assign serial_out_b = ser_b_ff;
	assign first_data = first_ff;
	assign data_bus_oe_n = ~((mode != ACPL_MODE_SERIAL) & ~cs_n & ~dual & ~cs_rise);
	assign serial_oe_n = ~((mode == ACPL_MODE_SERIAL) & ~cs_n);
	assign first_data_oe_n = cs_n;

	// ********************************
	// AXI4-Lite slave
	// ********************************
	logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic [3:0] wstrb_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic do_write;

	assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
	assign s_axi_wready = ~w_got_ff & ~bvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = ~rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign do_write = aw_got_ff & w_got_ff & ~bvalid_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= 2'h0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff <= (awaddr_ff == ACPL_CTRL_OFF || awaddr_ff == ACPL_RES_SEL_OFF) ? 2'h0 : 2'h2;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_en_ff <= ACPL_START_EN_RST;
			conv_len_ff <= ACPL_CONV_LEN_RST;
			res_sel_ff <= ACPL_RES_SEL_RST;
		end else if (do_write) begin
			if (awaddr_ff == ACPL_CTRL_OFF && wstrb_ff[0]) begin
				start_en_ff <= wdata_ff[ACPL_CTRL_START_EN_BIT];
			end
			// A zero length would wrap the end count to 255 and stretch each channel to 256 cycles, so it is raised to one.
			if (awaddr_ff == ACPL_CTRL_OFF && wstrb_ff[1]) begin
				conv_len_ff <= (wdata_ff[ACPL_CTRL_LEN_LSB +: 8] == 8'h00) ? 8'h01 : wdata_ff[ACPL_CTRL_LEN_LSB +: 8];
			end
			if (awaddr_ff == ACPL_RES_SEL_OFF && wstrb_ff[0]) begin
				res_sel_ff <= wdata_ff[2:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= 2'h0;
			rdata_ff <= 32'h0000_0000;
			unique case (s_axi_araddr)
				ACPL_CTRL_OFF: begin
					rdata_ff[ACPL_CTRL_START_EN_BIT] <= start_en_ff;
					rdata_ff[ACPL_CTRL_LEN_LSB +: 8] <= conv_len_ff;
				end
				ACPL_STATUS_OFF: begin
					rdata_ff[ACPL_ST_BUSY_BIT] <= busy;
					rdata_ff[ACPL_ST_VALID_BIT] <= valid_ff;
					rdata_ff[ACPL_ST_MODE_LSB +: 2] <= mode;
					rdata_ff[ACPL_ST_STANDBY_BIT] <= power_standby;
					rdata_ff[ACPL_ST_SHUTDOWN_BIT] <= power_shutdown;
					rdata_ff[ACPL_ST_RESET_BIT] <= rst_pin;
					rdata_ff[ACPL_ST_CS_BIT] <= cs_n;
				end
				ACPL_RES_SEL_OFF: begin
					rdata_ff[2:0] <= res_sel_ff;
				end
				ACPL_RES_DATA_OFF: begin
					rdata_ff[CODE_W-1:0] <= result_ff[res_sel_ff];
				end
				default: begin
					rresp_ff <= 2'h2;
				end
			endcase
		end else if (rvalid_ff && s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end
endmodule // acpl_ctrl

// *** rtl/acpl_pkg.sv ***
// Package of constants and types shared by the converter control-pin logic.
package acpl_pkg;

	// ********************************
	// Register map
	// ********************************
	localparam logic [7:0] ACPL_CTRL_OFF = 8'h00;
	localparam logic [7:0] ACPL_STATUS_OFF = 8'h04;
	localparam logic [7:0] ACPL_RES_SEL_OFF = 8'h08;
	localparam logic [7:0] ACPL_RES_DATA_OFF = 8'h0c;

	// ********************************
	// Field positions and reset values
	// ********************************
	localparam int ACPL_CTRL_START_EN_BIT = 0;
	localparam int ACPL_CTRL_LEN_LSB = 8;
	localparam int ACPL_ST_BUSY_BIT = 0;
	localparam int ACPL_ST_VALID_BIT = 1;
	localparam int ACPL_ST_MODE_LSB = 2;
	localparam int ACPL_ST_STANDBY_BIT = 4;
	localparam int ACPL_ST_SHUTDOWN_BIT = 5;
	localparam int ACPL_ST_RESET_BIT = 6;
	localparam int ACPL_ST_CS_BIT = 7;
	localparam logic ACPL_START_EN_RST = 1'b1;
	localparam logic [2:0] ACPL_RES_SEL_RST = 3'h0;

	// ********************************
	// Geometry and timing
	// ********************************
	localparam int ACPL_CHANNELS = 8;
	localparam int ACPL_CODE_W = 14;
	localparam int ACPL_BUS_W = 16;
	localparam int ACPL_SYNC_W = 9;
	localparam int ACPL_CLK_PERIOD_NS = 10;
	localparam int ACPL_CONV_TIME_NS = 500;
	localparam int ACPL_CONV_CYCLES = (ACPL_CONV_TIME_NS + ACPL_CLK_PERIOD_NS - 1) / ACPL_CLK_PERIOD_NS;
	localparam logic [7:0] ACPL_CONV_LEN_RST = 8'(ACPL_CONV_CYCLES);

	// ********************************
	// Types
	// ********************************
	typedef enum logic [1:0] {
		ACPL_MODE_PAR_WORD,
		ACPL_MODE_PAR_BYTE,
		ACPL_MODE_SERIAL
	} acpl_mode_t;

	typedef enum logic [1:0] {
		ACPL_CV_IDLE,
		ACPL_CV_HOLD,
		ACPL_CV_RUN
	} acpl_cv_t;

endpackage

// *** rtl/acpl_sync.sv ***
// Two-stage synchroniser for a vector of pin inputs, with a registered copy for edge finding.
`timescale 1ns/1ps
module acpl_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pins in, synchronised levels out
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] level_out,
	output logic [WIDTH-1:0] level_prev
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] prev_ff;

	// The first stage feeds only the second stage.
	always_ff @(posedge aclk) begin
		meta_ff <= pin_in;
		sync_ff <= meta_ff;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Loading the live level keeps a pin that idles high from showing a false edge after reset.
			prev_ff <= sync_ff;
		end else begin
			prev_ff <= sync_ff;
		end
	end

	assign level_out = sync_ff;
	assign level_prev = prev_ff;
endmodule // acpl_sync

// *** test/acpl_host_model.sv ***
// Behavioural host that drives chip select and the read strobe or serial clock.
`timescale 1ns/1ps
module acpl_host_model (
	// Requests from the bench
	input wire logic frame,
	input wire logic go,
	input wire logic [4:0] npulse,
	// Pins towards the block, and the idle flag back to the bench
	output logic chip_select_n,
	output logic read_strobe_sclk,
	output logic idle
);
	assign chip_select_n = ~frame;
	// The pin stands still outside bursts and runs at 125 ns, unrelated in phase to the bench clock.
	initial begin
		read_strobe_sclk = 1'h1;
		idle = 1'h1;
		forever begin
			@(posedge go);
			idle = 1'h0;
			repeat (npulse) begin
				#31.25 read_strobe_sclk = 1'h0;
				#62.5 read_strobe_sclk = 1'h1;
				#31.25;
			end
			idle = 1'h1;
		end
	end
endmodule // acpl_host_model

// *** test/acpl_ctrl_assertions.sv ***
// Concurrent checks on the ports of the control-pin block.
`timescale 1ns/1ps
module acpl_ctrl_checker (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pins and outputs watched
	input wire logic power_down_n,
	input wire logic input_span_select,
	input wire logic interface_select,
	input wire logic sample_start_group_a,
	input wire logic sample_start_group_b,
	input wire logic reset_pin,
	input wire logic chip_select_n,
	input wire logic read_strobe_sclk,
	input wire logic busy,
	input wire logic data_bus_oe_n,
	input wire logic serial_oe_n,
	input wire logic first_data_oe_n,
	input wire logic power_standby,
	input wire logic power_shutdown
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Pin levels pass a two-flop synchroniser, so each level rule allows a few cycles to settle.
	standby_map_a: assert property ((!power_down_n && !input_span_select)[*5] |-> power_standby)
		else $error("standby not entered");
	shutdown_map_a: assert property ((!power_down_n && input_span_select)[*5] |-> power_shutdown && !power_standby)
		else $error("shutdown not entered");
	awake_state_a: assert property (power_down_n[*5] |-> !power_standby && !power_shutdown)
		else $error("power-down while pin high");
	busy_cause_a: assert property ($rose(busy) |-> sample_start_group_a && sample_start_group_b)
		else $error("busy rose without both starts");
	busy_hold_a: assert property ($rose(busy) |-> busy[*8])
		else $error("busy shorter than eight slots");
	reset_idle_a: assert property (reset_pin[*6] |-> !busy)
		else $error("busy under reset pin");
	reset_abort_a: assert property ($rose(reset_pin) && busy |-> ##[1:6] !busy)
		else $error("conversion not aborted");
	word_drive_a: assert property ((!chip_select_n && !read_strobe_sclk && !interface_select)[*5] |-> !data_bus_oe_n)
		else $error("data bus not driven");
	strobe_off_a: assert property (read_strobe_sclk[*5] |-> data_bus_oe_n)
		else $error("data bus driven without strobe");
	cs_tristate_a: assert property (chip_select_n[*5] |-> data_bus_oe_n && serial_oe_n && first_data_oe_n)
		else $error("outputs driven while deselected");
endmodule // acpl_ctrl_checker

bind acpl_ctrl acpl_ctrl_checker u_chk (.aclk, .aresetn, .power_down_n, .input_span_select, .interface_select,
	.sample_start_group_a, .sample_start_group_b, .reset_pin, .chip_select_n, .read_strobe_sclk, .busy,
	.data_bus_oe_n, .serial_oe_n, .first_data_oe_n, .power_standby, .power_shutdown);

// *** test/acpl_ctrl_tb.sv ***
// Self-checking bench for the converter control-pin block.
`timescale 1ns/1ps
module acpl_ctrl_tb
	import acpl_pkg::*;
;
	typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} acpl_exp_t;
	logic aclk = 0, aresetn = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic power_down_n = 1, input_span_select = 0, interface_select = 0, byte_mode_select_in = 0;
	logic sample_start_group_a = 0, sample_start_group_b = 0, reset_pin = 0;
	logic chip_select_n, read_strobe_sclk, host_idle, frame = 0, go = 0;
	logic [4:0] npulse = 0;
	logic [2:0] adc_channel;
	logic [13:0] adc_code, base = 0;
	logic [15:0] data_bus_out;
	logic busy, data_bus_oe_n, serial_out_a, serial_out_b, serial_oe_n, first_data, first_data_oe_n;
	logic power_standby, power_shutdown;
	logic [8:0] busy_run = 0, last_len = 0;
	int err_total = 0, total_checks = 0;
	acpl_exp_t exp_r[$], er;
	logic [1:0] exp_b[$];

	acpl_ctrl DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_down_n, .input_span_select,
		.interface_select, .sample_start_group_a, .sample_start_group_b, .reset_pin, .chip_select_n,
		.read_strobe_sclk, .byte_mode_select_in, .adc_channel, .adc_code, .busy, .data_bus_out, .data_bus_oe_n,
		.serial_out_a, .serial_out_b, .serial_oe_n, .first_data, .first_data_oe_n, .power_standby, .power_shutdown);
	acpl_host_model u_host (.frame, .go, .npulse, .chip_select_n, .read_strobe_sclk, .idle(host_idle));
	assign adc_code = base ^ {11'h0, adc_channel};
	always #5 aclk = ~aclk;

	// ********************************
	// Checking and bus tasks
	// ********************************
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic timed_out;
		err_total++;
		final_report();
	endtask

	// Ready is sampled at the falling edge, where it already holds its value for the next rising edge.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw_ok, w_ok, hs;
		hs = 0;
		exp_b.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (int i = 0; i < 50 && !hs; i++) begin
			@(negedge aclk);
			aw_ok = s_axi_awvalid && s_axi_awready;
			w_ok = s_axi_wvalid && s_axi_wready;
			hs = s_axi_bvalid;
			@(posedge aclk);
			if (aw_ok) s_axi_awvalid <= 0;
			if (w_ok) s_axi_wvalid <= 0;
		end
		s_axi_bready <= 0;
		if (!hs) timed_out();
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
		logic ar_ok, hs;
		hs = 0;
		exp_r.push_back('{d & m, m, r});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (int i = 0; i < 50 && !hs; i++) begin
			@(negedge aclk);
			ar_ok = s_axi_arvalid && s_axi_arready;
			hs = s_axi_rvalid;
			@(posedge aclk);
			if (ar_ok) s_axi_arvalid <= 0;
		end
		s_axi_rready <= 0;
		if (!hs) timed_out();
		@(posedge aclk);
	endtask

	task automatic wait_busy(input logic lvl);
		int n;
		for (n = 0; n < 300 && busy !== lvl; n++) @(negedge aclk);
		if (busy !== lvl) timed_out();
		@(posedge aclk);
	endtask

	task automatic set_starts(input logic v);
		sample_start_group_a <= v;
		sample_start_group_b <= v;
	endtask

	task automatic host_pulses(input logic [4:0] k);
		int n;
		npulse <= k;
		go <= 1;
		@(posedge aclk);
		go <= 0;
		for (n = 0; n < 2000 && !host_idle; n++) @(negedge aclk);
		if (!host_idle) timed_out();
		repeat (6) @(posedge aclk);
	endtask

	// ********************************
	// Result monitor
	// ********************************
	always @(posedge aclk) begin
		busy_run <= busy ? busy_run + 9'h1 : 9'h0;
		if (!busy && busy_run != 0) last_len <= busy_run;
		if (s_axi_rvalid && s_axi_rready) begin
			er = exp_r.pop_front();
			check("rdata", s_axi_rdata & er.m, er.d);
			check("rresp", 32'(s_axi_rresp), 32'(er.r));
		end
		if (s_axi_bvalid && s_axi_bready) check("bresp", 32'(s_axi_bresp), 32'(exp_b.pop_front()));
	end

	// ********************************
	// Main sequence
	// ********************************
	initial begin
		logic [1:0] ifs[3] = '{2'h0, 2'h3, 2'h2};
		logic [4:0] keep[3] = '{5'h1, 5'h2, 5'hd};
		logic [13:0] nb;
		void'($urandom(32'h9ad17b5c));
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		base <= 14'($urandom);
		axi_rd(ACPL_CTRL_OFF, 32'h0000_3201, 32'h0000_ffff, 2'h0);
		axi_rd(8'h10, 32'h0, 32'h0, 2'h2);
		axi_wr(ACPL_STATUS_OFF, 32'h0, 2'h2);
		axi_wr(ACPL_CTRL_OFF, 32'h0000_0401, 2'h0);
		set_starts(1);
		wait_busy(1);
		repeat (4) @(posedge aclk);
		set_starts(0);
		@(posedge aclk);
		set_starts(1);
		wait_busy(0);
		@(posedge aclk);
		check("busy length", 32'(last_len), 32'h20);
		set_starts(0);
		for (int i = 0; i < 8; i++) begin
			axi_wr(ACPL_RES_SEL_OFF, 32'(i), 2'h0);
			axi_rd(ACPL_RES_DATA_OFF, 32'(base ^ 14'(i)), 32'h3fff, 2'h0);
		end
		axi_rd(ACPL_STATUS_OFF, 32'h0000_0082, 32'h0000_00ff, 2'h0);
		set_starts(1);
		wait_busy(1);
		repeat (8) @(posedge aclk);
		reset_pin <= 1;
		wait_busy(0);
		repeat (10) @(posedge aclk);
		set_starts(0);
		reset_pin <= 0;
		axi_wr(ACPL_RES_SEL_OFF, 32'h0, 2'h0);
		axi_rd(ACPL_RES_DATA_OFF, 32'h0, 32'h3fff, 2'h0);
		axi_rd(ACPL_STATUS_OFF, 32'h0000_0080, 32'h0000_00ff, 2'h0);
		repeat (20) @(posedge aclk);
		reset_pin <= 1;
		repeat (5) @(posedge aclk);
		set_starts(1);
		repeat (10) @(posedge aclk);
		reset_pin <= 0;
		repeat (10) @(posedge aclk);
		check("busy under reset", 32'(busy), 32'h0);
		set_starts(0);
		power_down_n <= 0;
		input_span_select <= 1;
		repeat (6) @(posedge aclk);
		check("shutdown", 32'({power_standby, power_shutdown}), 32'h1);
		input_span_select <= 0;
		set_starts(1);
		repeat (8) @(posedge aclk);
		check("standby", 32'({power_standby, power_shutdown}), 32'h2);
		check("busy in power-down", 32'(busy), 32'h0);
		set_starts(0);
		power_down_n <= 1;
		repeat (6) @(posedge aclk);
		check("awake", 32'({power_standby, power_shutdown}), 32'h0);
		repeat (40) @(posedge aclk);
		reset_pin <= 1;
		repeat (4) @(posedge aclk);
		reset_pin <= 0;
		repeat (20) @(posedge aclk);
		base <= 14'($urandom);
		set_starts(1);
		wait_busy(1);
		wait_busy(0);
		set_starts(0);
		nb = base ^ 14'h1;
		for (int m = 0; m < 3; m++) begin
			interface_select <= ifs[m][1];
			byte_mode_select_in <= ifs[m][0];
			repeat (4) @(posedge aclk);
			frame <= 1;
			repeat (6) @(posedge aclk);
			host_pulses(keep[m]);
			check("first channel flag", 32'(first_data), 32'h1);
			if (m == 2) check("serial lsb", 32'({serial_out_a, serial_out_b}), 32'({2{base[0]}}));
			else check("bus lead", 32'(data_bus_out), 32'(m == 0 ? {{2{base[13]}}, base} : {8'h00, base[7:0]}));
			host_pulses(5'h1);
			check("first channel flag", 32'(first_data), 32'h0);
			if (m == 2) check("serial msb", 32'({serial_out_a, serial_out_b}), 32'({2{nb[13]}}));
			else check("bus next", 32'(data_bus_out), 32'(m == 0 ? {{2{nb[13]}}, nb} : {8'h00, {2{nb[13]}}, nb[13:8]}));
			frame <= 0;
			repeat (6) @(posedge aclk);
		end
		final_report();
	end
endmodule // acpl_ctrl_tb
